//--- common/sas_consts.vh
// Constants for the snooze acquisition sequencer.
`ifndef SAS_CONSTS_VH
`define SAS_CONSTS_VH
// ============================================================
// Timing
`define SAS_CLK_HZ 125000000
`define SAS_SECOND_CYCLES (`SAS_CLK_HZ)
`define SAS_MINUTE_SECONDS 60
`define SAS_PERIOD_MINUTES 30
`define SAS_ALARM_HOURS 24
`define SAS_ALARM_MINUTES (`SAS_ALARM_HOURS * 60)
// ============================================================
// Operating modes
`define SAS_MODE_W 3
`define SAS_MODE_NORMAL 3'h0
`define SAS_MODE_SLEEP 3'h1
`define SAS_MODE_STANDBY 3'h2
`define SAS_MODE_SNOOZE 3'h3
`define SAS_MODE_DEEP 3'h4
// ============================================================
// Wake cause bit positions
`define SAS_CAUSE_ALARM 0
`define SAS_CAUSE_PIN 1
`define SAS_CAUSE_CMP 2
// ============================================================
// Chained transfer steps
`define SAS_STEP_W 3
`define SAS_STEP_IDLE 3'h0
`define SAS_STEP_BUF0 3'h1
`define SAS_STEP_BUF1 3'h2
`define SAS_STEP_THR 3'h3
`define SAS_STEP_CMP 3'h4
// ============================================================
// Sizes
`define SAS_DATA_W 12
`define SAS_BUF_DEPTH 48
`define SAS_PTR_W 6
`endif

//--- rtl/sas_interval_timer.v
// Reloading down counter that pulses once per RELOAD source ticks.
`timescale 1ns/1ns
module sas_interval_timer #(
  parameter W = 8,
  parameter [W-1:0] RELOAD = 8'h3C
)(
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire run,
  input wire tick,
  output reg underflow_q
);
  reg [W-1:0] count_q;

  // ============================================================
  // Count
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      count_q <= RELOAD - 1'b1;
      underflow_q <= 1'b0;
    end
    else if (ce)
    begin
      underflow_q <= 1'b0;
      if (run && tick)
      begin
        if (count_q == {W{1'b0}})
        begin
          count_q <= RELOAD - 1'b1;
          underflow_q <= 1'b1;
        end
        else
        begin
          count_q <= count_q - 1'b1;
        end
      end
    end
  end
endmodule

//--- rtl/sas_comparator.v
// Subtraction-mode data comparator: flags input at or above the threshold.
`timescale 1ns/1ns
`include "sas_consts.vh"
module sas_comparator #(
  parameter W = `SAS_DATA_W
)(
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire thr_we,
  input wire [W-1:0] thr_data,
  input wire data_we,
  input wire [W-1:0] data_in,
  output reg hit_q
);
  reg [W-1:0] thr_q;
  wire [W:0] diff;

  // The borrow of the subtraction is the whole decision.
  assign diff = {1'b0, data_in} - {1'b0, thr_q};

  // ============================================================
  // Threshold and judgment
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      thr_q <= {W{1'b0}};
      hit_q <= 1'b0;
    end
    else if (ce)
    begin
      hit_q <= 1'b0;
      if (thr_we)
        thr_q <= thr_data;
      if (data_we)
        hit_q <= ~diff[W];
    end
  end
endmodule

//--- rtl/sas_sequencer.v
// Low-power mode sequencer with timed snooze acquisition and level judgment.
`timescale 1ns/1ns
`include "sas_consts.vh"
// Notes on behaviour
// - First timer underflows once per minute
// - Second timer underflows every thirty minutes
// - Period underflow moves standby into snooze
// - Conversion start from underflow or snooze request
// - Chain: buffer0, buffer1, threshold, comparator input
// - Comparator hits when value at least threshold
// - Comparator hit cancels snooze to normal
// - Chain completion returns snooze to standby
// - Alarm, pin or hit wakes to normal
// - Calendar runs always, alarms every 24 hours
// - Sleep exits on reset or linked interrupt
// - Standby stops processor, peripherals, oscillators
// - Snooze only from standby, restricted peripherals
// - Deep standby powers down all but calendar
// - Event assignment for snooze, end, wake
module sas_sequencer #(
  parameter SECOND_CYCLES = `SAS_SECOND_CYCLES,
  parameter DEPTH = `SAS_BUF_DEPTH,
  parameter PW = `SAS_PTR_W,
  parameter DW = `SAS_DATA_W
)(
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire sleep_req,
  input wire standby_req,
  input wire deep_req,
  input wire irq_any,
  input wire irq_link_en,
  input wire pin_irq,
  input wire alarm_rearm,
  input wire trig_from_snooze,
  input wire adc_conv_done,
  input wire [DW-1:0] adc_ch0_data,
  input wire [DW-1:0] adc_ch1_data,
  input wire [DW-1:0] threshold,
  input wire [PW-1:0] buf_rd_addr,
  output reg [`SAS_MODE_W-1:0] mode_q,
  output reg cpu_run_q,
  output reg periph_run_q,
  output reg osc_run_q,
  output reg core_power_q,
  output reg adc_start_q,
  output reg transfer_done_q,
  output reg comparator_hit_q,
  output reg alarm_pending_q,
  output reg [2:0] wake_cause_q,
  output reg [PW-1:0] buf_wr_ptr_q,
  output reg [2*DW-1:0] buf_rd_data_q
);
  // ============================================================
  // Declarations
  reg [31:0] presc_q;
  reg sec_tick_q;
  reg alarm_armed_q;
  reg [`SAS_STEP_W-1:0] step_q;
  reg [`SAS_MODE_W-1:0] mode_d;
  reg [DW-1:0] buf0_mem [0:DEPTH-1];
  reg [DW-1:0] buf1_mem [0:DEPTH-1];
  reg done_q;
  wire minute_uf;
  wire period_uf;
  wire alarm_uf;
  wire cmp_hit;
  wire alarm_event;
  wire wake_event;
  wire snooze_req;
  wire in_standby;
  wire in_snooze;
  wire deep;
  wire thr_we;
  wire cmp_we;

  assign in_standby = (mode_q == `SAS_MODE_STANDBY);
  assign in_snooze = (mode_q == `SAS_MODE_SNOOZE);
  assign deep = (mode_q == `SAS_MODE_DEEP);
  assign alarm_event = alarm_uf & alarm_armed_q;
  assign wake_event = pin_irq | alarm_event | cmp_hit;
  assign snooze_req = in_standby & period_uf & ~wake_event;
  assign thr_we = (step_q == `SAS_STEP_THR);
  assign cmp_we = (step_q == `SAS_STEP_CMP);

  // ============================================================
  // Seconds prescaler; runs from power-on in every mode.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      presc_q <= 32'h00000000;
      sec_tick_q <= 1'b0;
    end
    else if (ce)
    begin
      sec_tick_q <= 1'b0;
      if (presc_q == SECOND_CYCLES - 1)
      begin
        presc_q <= 32'h00000000;
        sec_tick_q <= 1'b1;
      end
      else
      begin
        presc_q <= presc_q + 32'h00000001;
      end
    end
  end

  // ============================================================
  // Cascaded interval timers and calendar alarm
  sas_interval_timer #(.W(6), .RELOAD(6'h3C)) u_minute_interval_timer (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .run(~deep),
    .tick(sec_tick_q),
    .underflow_q(minute_uf)
  );

  // The minute underflow is the only count source of the period timer.
  sas_interval_timer #(.W(5), .RELOAD(5'h1E)) u_period_interval_timer (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .run(~deep),
    .tick(minute_uf),
    .underflow_q(period_uf)
  );

  // The calendar keeps its own minute chain so it survives deep standby.
  wire cal_minute;
  sas_interval_timer #(.W(6), .RELOAD(6'h3C)) u_calendar_minute (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .run(1'b1),
    .tick(sec_tick_q),
    .underflow_q(cal_minute)
  );

  sas_interval_timer #(.W(11), .RELOAD(11'h5A0)) u_calendar_alarm (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .run(1'b1),
    .tick(cal_minute),
    .underflow_q(alarm_uf)
  );

  // Once fired, the alarm stays silent until software arms the next one.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      alarm_armed_q <= 1'b1;
      alarm_pending_q <= 1'b0;
    end
    else if (ce)
    begin
      if (alarm_event)
      begin
        alarm_armed_q <= 1'b0;
        alarm_pending_q <= 1'b1;
      end
      else if (alarm_rearm)
      begin
        alarm_armed_q <= 1'b1;
        alarm_pending_q <= 1'b0;
      end
    end
  end

  // ============================================================
  // Conversion start through the event link
  always @(posedge clk)
  begin
    if (!rst_n)
      adc_start_q <= 1'b0;
    else if (ce)
    begin
      if (trig_from_snooze)
        adc_start_q <= snooze_req;
      else
        adc_start_q <= period_uf & ~deep & (mode_q != `SAS_MODE_STANDBY | snooze_req);
    end
  end

  // ============================================================
  // Chained transfer in repeat mode
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      step_q <= `SAS_STEP_IDLE;
      done_q <= 1'b0;
      buf_wr_ptr_q <= {PW{1'b0}};
    end
    else if (ce)
    begin
      done_q <= 1'b0;
      case (step_q)
        `SAS_STEP_IDLE:
        begin
          if (adc_conv_done && !in_standby && !deep)
            step_q <= `SAS_STEP_BUF0;
        end
        `SAS_STEP_BUF0:
          step_q <= `SAS_STEP_BUF1;
        `SAS_STEP_BUF1:
          step_q <= `SAS_STEP_THR;
        `SAS_STEP_THR:
          step_q <= `SAS_STEP_CMP;
        `SAS_STEP_CMP:
        begin
          step_q <= `SAS_STEP_IDLE;
          done_q <= 1'b1;
          if (buf_wr_ptr_q == DEPTH - 1)
            buf_wr_ptr_q <= {PW{1'b0}};
          else
            buf_wr_ptr_q <= buf_wr_ptr_q + 1'b1;
        end
        default:
          step_q <= `SAS_STEP_IDLE;
      endcase
    end
  end

  always @(posedge clk)
  begin
    if (ce && step_q == `SAS_STEP_BUF0)
      buf0_mem[buf_wr_ptr_q] <= adc_ch0_data;
    if (ce && step_q == `SAS_STEP_BUF1)
      buf1_mem[buf_wr_ptr_q] <= adc_ch1_data;
  end

  always @(posedge clk)
  begin
    if (!rst_n)
      buf_rd_data_q <= {2 * DW{1'b0}};
    else if (ce)
      buf_rd_data_q <= {buf1_mem[buf_rd_addr], buf0_mem[buf_rd_addr]};
  end

  sas_comparator #(.W(DW)) u_data_operation_comparator (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .thr_we(thr_we),
    .thr_data(threshold),
    .data_we(cmp_we),
    .data_in(adc_ch1_data),
    .hit_q(cmp_hit)
  );

  // ============================================================
  // Mode transitions
  always @*
  begin
    mode_d = mode_q;
    case (mode_q)
      `SAS_MODE_NORMAL:
      begin
        if (deep_req)
          mode_d = `SAS_MODE_DEEP;
        else if (standby_req)
          mode_d = `SAS_MODE_STANDBY;
        else if (sleep_req)
          mode_d = `SAS_MODE_SLEEP;
      end
      `SAS_MODE_SLEEP:
      begin
        if ((irq_any && irq_link_en) || wake_event)
          mode_d = `SAS_MODE_NORMAL;
      end
      `SAS_MODE_STANDBY:
      begin
        if (wake_event)
          mode_d = `SAS_MODE_NORMAL;
        else if (snooze_req)
          mode_d = `SAS_MODE_SNOOZE;
      end
      `SAS_MODE_SNOOZE:
      begin
        if (wake_event)
          mode_d = `SAS_MODE_NORMAL;
        else if (done_q)
          mode_d = `SAS_MODE_STANDBY;
      end
      `SAS_MODE_DEEP:
      begin
        if (pin_irq || alarm_event)
          mode_d = `SAS_MODE_NORMAL;
      end
      default:
        mode_d = `SAS_MODE_NORMAL;
    endcase
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      mode_q <= `SAS_MODE_NORMAL;
      cpu_run_q <= 1'b1;
      periph_run_q <= 1'b1;
      osc_run_q <= 1'b1;
      core_power_q <= 1'b1;
      transfer_done_q <= 1'b0;
      comparator_hit_q <= 1'b0;
      wake_cause_q <= 3'h0;
    end
    else if (ce)
    begin
      mode_q <= mode_d;
      cpu_run_q <= (mode_d == `SAS_MODE_NORMAL);
      periph_run_q <= (mode_d == `SAS_MODE_NORMAL) || (mode_d == `SAS_MODE_SLEEP) ||
                      (mode_d == `SAS_MODE_SNOOZE);
      osc_run_q <= (mode_d != `SAS_MODE_STANDBY) && (mode_d != `SAS_MODE_DEEP);
      core_power_q <= (mode_d != `SAS_MODE_DEEP);
      transfer_done_q <= done_q;
      comparator_hit_q <= cmp_hit;
      if (mode_d == `SAS_MODE_NORMAL && mode_q != `SAS_MODE_NORMAL)
      begin
        wake_cause_q[`SAS_CAUSE_ALARM] <= alarm_event;
        wake_cause_q[`SAS_CAUSE_PIN] <= pin_irq;
        wake_cause_q[`SAS_CAUSE_CMP] <= cmp_hit;
      end
    end
  end
endmodule

//--- tb/sas_seq_assertions.sv
// Port-level assertion checker for the snooze acquisition sequencer.
`timescale 1ns/1ns
`include "sas_consts.vh"
module sas_seq_checker (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire sleep_req,
  input wire standby_req,
  input wire deep_req,
  input wire irq_any,
  input wire irq_link_en,
  input wire pin_irq,
  input wire [`SAS_MODE_W-1:0] mode_q,
  input wire cpu_run_q,
  input wire periph_run_q,
  input wire osc_run_q,
  input wire core_power_q,
  input wire adc_start_q,
  input wire transfer_done_q,
  input wire comparator_hit_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ============================================================
  // Mode transitions
  property p_std;
    mode_q == `SAS_MODE_NORMAL && standby_req && !deep_req && ce |=> mode_q == `SAS_MODE_STANDBY;
  endproperty
  a_std: assert property (p_std) else $error("standby request not taken");
  property p_off;
    mode_q == `SAS_MODE_STANDBY |-> !cpu_run_q && !periph_run_q && !osc_run_q;
  endproperty
  a_off: assert property (p_off) else $error("standby left something running");
  property p_deep;
    mode_q == `SAS_MODE_NORMAL && deep_req && ce |=> mode_q == `SAS_MODE_DEEP ##0 !core_power_q;
  endproperty
  a_deep: assert property (p_deep) else $error("deep standby not entered with power off");
  property p_snz;
    $rose(mode_q == `SAS_MODE_SNOOZE) |-> $past(mode_q) == `SAS_MODE_STANDBY;
  endproperty
  a_snz: assert property (p_snz) else $error("snooze entered from a mode other than standby");
  property p_adc;
    mode_q == `SAS_MODE_SNOOZE && $past(mode_q) == `SAS_MODE_STANDBY |-> adc_start_q;
  endproperty
  a_adc: assert property (p_adc) else $error("no conversion start on snooze entry");
  property p_adcp;
    adc_start_q |=> !adc_start_q;
  endproperty
  a_adcp: assert property (p_adcp) else $error("conversion start longer than one cycle");
  // ============================================================
  // Snooze, standby and sleep exits
  property p_done;
    transfer_done_q && !comparator_hit_q && $past(mode_q) == `SAS_MODE_SNOOZE && !$past(pin_irq)
      |-> mode_q == `SAS_MODE_STANDBY;
  endproperty
  a_done: assert property (p_done) else $error("chain done did not return to standby");
  property p_hit;
    comparator_hit_q && $past(mode_q) == `SAS_MODE_SNOOZE |-> mode_q == `SAS_MODE_NORMAL;
  endproperty
  a_hit: assert property (p_hit) else $error("comparator hit did not wake to normal");
  property p_pin;
    mode_q == `SAS_MODE_STANDBY && pin_irq && ce |=> mode_q == `SAS_MODE_NORMAL;
  endproperty
  a_pin: assert property (p_pin) else $error("pin event did not wake standby");
  property p_sleep;
    mode_q == `SAS_MODE_SLEEP && irq_any && irq_link_en && ce |=> mode_q == `SAS_MODE_NORMAL;
  endproperty
  a_sleep: assert property (p_sleep) else $error("linked interrupt did not end sleep");
  // The processor, peripheral and core power flags must follow the mode, so a stray flag shows up in sleep and snooze as well.
  property p_cpu;
    cpu_run_q == (mode_q == `SAS_MODE_NORMAL) &&
      periph_run_q == (mode_q != `SAS_MODE_STANDBY && mode_q != `SAS_MODE_DEEP) &&
      core_power_q == (mode_q != `SAS_MODE_DEEP);
  endproperty
  a_cpu: assert property (p_cpu) else $error("run flags disagree with mode");
endmodule
bind sas_sequencer sas_seq_checker sas_seq_checker_inst (.clk, .rst_n, .ce, .sleep_req, .standby_req,
  .deep_req, .irq_any, .irq_link_en, .pin_irq, .mode_q, .cpu_run_q, .periph_run_q, .osc_run_q,
  .core_power_q, .adc_start_q, .transfer_done_q, .comparator_hit_q);

//--- tb/sas_sensor_model.sv
// Behavioural two-channel converter that answers each conversion start.
`timescale 1ns/1ns
`include "sas_consts.vh"
module sas_sensor_model (
  input wire clk,
  input wire rst_n,
  input wire adc_start_q,
  input wire slow,
  input wire [`SAS_DATA_W-1:0] ch0_val,
  input wire [`SAS_DATA_W-1:0] ch1_val,
  output reg adc_conv_done,
  output reg [`SAS_DATA_W-1:0] adc_ch0_data,
  output reg [`SAS_DATA_W-1:0] adc_ch1_data
);
  initial adc_conv_done = 1'b0;
  initial adc_ch0_data = {`SAS_DATA_W{1'b1}};
  initial adc_ch1_data = {`SAS_DATA_W{1'b1}};
  // Results are only valid for the chain window; afterwards they flip so stale reads show.
  always
  begin
    @(posedge clk);
    if (rst_n && adc_start_q)
    begin
      repeat (slow ? 9 : 2) @(posedge clk);
      #1;
      adc_ch0_data = ch0_val;
      adc_ch1_data = ch1_val;
      adc_conv_done = 1'b1;
      @(posedge clk);
      #1;
      adc_conv_done = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      adc_ch0_data = ~ch0_val;
      adc_ch1_data = ~ch1_val;
    end
  end
endmodule

//--- tb/sas_sequencer_test.sv
// Self-checking bench for the snooze acquisition sequencer.
`timescale 1ns/1ns
`include "sas_consts.vh"
`define CHK(n, e, a) begin checked = checked + 1; if ((a) !== (e)) begin mismatches = mismatches + 1; \
  $display("[ERR] %s expected %h seen %h", n, e, a); end end
module sas_sequencer_test;
  localparam DW = `SAS_DATA_W;
  // A short second keeps the thirty-minute period within reach of the run.
  localparam SEC = 10;
  reg clk = 1'b0, rst_n = 1'b0, ce = 1'b1, sleep_req = 1'b0, standby_req = 1'b0, deep_req = 1'b0;
  reg irq_any = 1'b0, irq_link_en = 1'b0, pin_irq = 1'b0, alarm_rearm = 1'b0, trig_from_snooze = 1'b0;
  reg slow = 1'b0;
  reg [DW-1:0] threshold = 12'h000, ch0_val = 12'h000, ch1_val = 12'h000;
  reg [5:0] buf_rd_addr = 6'h00;
  wire adc_conv_done, cpu_run_q, periph_run_q, osc_run_q, core_power_q, adc_start_q;
  wire transfer_done_q, comparator_hit_q, alarm_pending_q;
  wire [DW-1:0] adc_ch0_data, adc_ch1_data;
  wire [2:0] mode_q, wake_cause_q;
  wire [5:0] buf_wr_ptr_q;
  wire [2*DW-1:0] buf_rd_data_q;
  integer mismatches = 0;
  integer checked = 0;
  integer cycle_n = 0;
  integer snooze_at = 0;
  reg [31:0] lfsr = 32'h21DC;
  always #4 clk = ~clk;
  always @(posedge clk)
    cycle_n <= cycle_n + 1;
  sas_sequencer #(.SECOND_CYCLES(SEC)) sas_sequencer_inst (.clk, .rst_n, .ce, .sleep_req, .standby_req,
    .deep_req, .irq_any, .irq_link_en, .pin_irq, .alarm_rearm, .trig_from_snooze, .adc_conv_done,
    .adc_ch0_data, .adc_ch1_data, .threshold, .buf_rd_addr, .mode_q, .cpu_run_q, .periph_run_q,
    .osc_run_q, .core_power_q, .adc_start_q, .transfer_done_q, .comparator_hit_q, .alarm_pending_q,
    .wake_cause_q, .buf_wr_ptr_q, .buf_rd_data_q);
  sas_sensor_model sas_sensor_model_inst (.clk, .rst_n, .adc_start_q, .slow, .ch0_val, .ch1_val,
    .adc_conv_done, .adc_ch0_data, .adc_ch1_data);
  // ============================================================
  // Helpers
  function [31:0] lfsr_next(input [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function exp_hit(input [DW-1:0] v, input [DW-1:0] t);
    exp_hit = v >= t;
  endfunction
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task wait_mode(input [2:0] m, input integer lim);
    integer i;
    begin
      i = 0;
      while (mode_q !== m && i < lim)
      begin
        cyc(1);
        i = i + 1;
      end
      `CHK("mode_q", m, mode_q)
    end
  endtask
  task snooze_round(input [DW-1:0] c1, input [DW-1:0] thr, input [5:0] slot);
    begin
      lfsr = lfsr_next(lfsr);
      ch0_val = lfsr[DW-1:0];
      ch1_val = c1;
      threshold = thr;
      slow = lfsr[20];
      trig_from_snooze = slot[0];
      wait_mode(`SAS_MODE_SNOOZE, 20000);
      if (slot != 6'h00)
        `CHK("period cycles", `SAS_PERIOD_MINUTES * `SAS_MINUTE_SECONDS * SEC, cycle_n - snooze_at)
      snooze_at = cycle_n;
      wait_mode(exp_hit(c1, thr) ? `SAS_MODE_NORMAL : `SAS_MODE_STANDBY, 40);
      if (exp_hit(c1, thr))
        `CHK("wake_cause_q", 3'h4, wake_cause_q)
      buf_rd_addr = slot;
      cyc(2);
      `CHK("buf_rd_data_q", {c1, ch0_val}, buf_rd_data_q)
      `CHK("buf_wr_ptr_q", slot + 6'h01, buf_wr_ptr_q)
    end
  endtask
  task complete_run;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // ============================================================
  // Main sequence
  initial
  begin
    cyc(20);
    rst_n = 1'b1;
    `CHK("reset outputs", {3'h0, 4'hF, 3'h0, 6'h00}, {mode_q, cpu_run_q, periph_run_q, osc_run_q, core_power_q, wake_cause_q, buf_wr_ptr_q})
    standby_req = 1'b1;
    cyc(1);
    standby_req = 1'b0;
    `CHK("standby outputs", {3'h2, 3'h0}, {mode_q, cpu_run_q, periph_run_q, osc_run_q})
    lfsr = lfsr_next(lfsr);
    snooze_round({1'b0, lfsr[10:0]}, 12'h800, 6'h00);
    snooze_round(12'h800, 12'h800, 6'h01);
    alarm_rearm = 1'b1;
    cyc(1);
    alarm_rearm = 1'b0;
    standby_req = 1'b1;
    cyc(1);
    standby_req = 1'b0;
    cyc(2);
    pin_irq = 1'b1;
    cyc(1);
    pin_irq = 1'b0;
    `CHK("pin wake", {3'h0, 3'h2}, {mode_q, wake_cause_q})
    sleep_req = 1'b1;
    cyc(1);
    sleep_req = 1'b0;
    irq_any = 1'b1;
    cyc(3);
    `CHK("unlinked irq", 3'h1, mode_q)
    irq_link_en = 1'b1;
    cyc(1);
    irq_any = 1'b0;
    `CHK("linked irq", 3'h0, mode_q)
    deep_req = 1'b1;
    standby_req = 1'b1;
    cyc(1);
    deep_req = 1'b0;
    standby_req = 1'b0;
    `CHK("deep entry", {3'h4, 1'b0}, {mode_q, core_power_q})
    pin_irq = 1'b1;
    cyc(1);
    pin_irq = 1'b0;
    `CHK("deep exit", 3'h0, mode_q)
    `CHK("alarm_pending_q", 1'b0, alarm_pending_q)
    complete_run;
  end
  initial
  begin
    #600000;
    mismatches = mismatches + 1;
    complete_run;
  end
endmodule
